// >>> hdl/exec_unit.sv
module exec_unit
(
  input  wire logic               clk_sys_i,
  input  wire logic               reset_i,
  input  wire logic               instr_valid_i,
  input  wire exec_pkg::instr_s   instr_i,
  input  wire logic [7:0]         file_rdata_i,
  input  wire logic [6:0]         pc_high_latch_i,
  input  wire logic [14:0]        pc_next_i,
  output logic [6:0]              file_raddr_o,
  output exec_pkg::fwrite_s       file_wr_o,
  output logic [7:0]              acc_o,
  output logic                    null_flag_o,
  output logic [14:0]             pc_o,
  output logic                    flush_o,
  output logic                    busy_o
);
  import exec_pkg::*;

  // ==========================================================
  // state
  typedef enum logic [0:0] {
    ST_RUN   = 1'b0,
    ST_FLUSH = 1'b1
  } state_e;

  state_e      state_q;
  logic [7:0]  acc_q;
  logic        null_q;
  logic [14:0] pc_q;
  fwrite_s     fwr_q;
  logic [7:0]  dec_val;
  logic [7:0]  inc_val;
  logic [7:0]  or_val;
  logic        exec_go;
  logic        skip_now;
  logic        jump_now;

  // ==========================================================
  // datapath
  // the operand slot in the flush cycle is a nop: nothing executes
  assign exec_go  = instr_valid_i && (state_q == ST_RUN);
  assign dec_val  = file_rdata_i - ONE_BYTE;
  assign inc_val  = file_rdata_i + ONE_BYTE;
  assign or_val   = acc_q | instr_i.imm[7:0];
  assign skip_now = exec_go && (
    ((instr_i.op == OP_DEC_SKIP) && (dec_val == ZERO_BYTE)) ||
    ((instr_i.op == OP_INC_SKIP) && (inc_val == ZERO_BYTE)));
  assign jump_now = exec_go && (instr_i.op == OP_JUMP);

  assign file_raddr_o = instr_i.faddr;
  assign file_wr_o    = fwr_q;
  assign acc_o        = acc_q;
  assign null_flag_o  = null_q;
  assign pc_o         = pc_q;
  assign flush_o      = (state_q == ST_FLUSH);
  assign busy_o       = (state_q == ST_FLUSH);

  // ==========================================================
  // sequencer: a skip whose result is zero and a jump take a second, nop cycle
  always_ff @(posedge clk_sys_i or posedge reset_i) begin
    if (reset_i) begin
      state_q <= ST_RUN;
    end else begin
      case (state_q)
        ST_RUN: begin
          if (skip_now || jump_now) begin
            state_q <= ST_FLUSH;
          end
        end
        ST_FLUSH: begin
          state_q <= ST_RUN;
        end
        default: begin
          state_q <= ST_RUN;
        end
      endcase
    end
  end

  // ==========================================================
  // accumulator
  always_ff @(posedge clk_sys_i or posedge reset_i) begin
    if (reset_i) begin
      acc_q <= ACC_RESET;
    end else if (exec_go) begin
      case (instr_i.op)
        OP_CLR_ACC: acc_q <= ZERO_BYTE;
        OP_DEC_FILE: begin
          if (!instr_i.dest) begin
            acc_q <= dec_val;
          end
        end
        OP_DEC_SKIP: begin
          if (!instr_i.dest) begin
            acc_q <= dec_val;
          end
        end
        OP_INC_SKIP: begin
          if (!instr_i.dest) begin
            acc_q <= inc_val;
          end
        end
        OP_OR_LIT: acc_q <= or_val;
        default: acc_q <= acc_q;
      endcase
    end
  end

  // ==========================================================
  // file register write port, one-cycle write strobe
  always_ff @(posedge clk_sys_i or posedge reset_i) begin
    if (reset_i) begin
      fwr_q <= '0;
    end else begin
      fwr_q.we   <= 1'b0;
      fwr_q.addr <= instr_i.faddr;
      fwr_q.data <= ZERO_BYTE;
      if (exec_go) begin
        case (instr_i.op)
          OP_CLR_FILE: begin
            fwr_q.we <= 1'b1;
          end
          OP_DEC_FILE, OP_DEC_SKIP: begin
            fwr_q.we   <= instr_i.dest;
            fwr_q.data <= dec_val;
          end
          OP_INC_SKIP: begin
            fwr_q.we   <= instr_i.dest;
            fwr_q.data <= inc_val;
          end
          default: fwr_q.we <= 1'b0;
        endcase
      end
    end
  end

  // ==========================================================
  // result-null flag; skips and the jump leave it alone
  always_ff @(posedge clk_sys_i or posedge reset_i) begin
    if (reset_i) begin
      null_q <= 1'b0;
    end else if (exec_go) begin
      case (instr_i.op)
        OP_CLR_FILE, OP_CLR_ACC: null_q <= 1'b1;
        OP_DEC_FILE: null_q <= (dec_val == ZERO_BYTE);
        OP_OR_LIT: null_q <= (or_val == ZERO_BYTE);
        default: null_q <= null_q;
      endcase
    end
  end

  // ==========================================================
  // program counter: the latch's full upper field wins over the
  // narrower two-bit reading, so all four upper bits are reachable
  always_ff @(posedge clk_sys_i or posedge reset_i) begin
    if (reset_i) begin
      pc_q <= PC_RESET;
    end else if (jump_now) begin
      pc_q <= {pc_high_latch_i[LATCH_W-1:LATCH_LO],
               instr_i.imm};
    end else if (exec_go) begin
      // the nop slot must not overwrite a freshly loaded jump target
      pc_q <= pc_next_i;
    end
  end

  // ==========================================================
  // checks
  sequence s_jump;
    jump_now;
  endsequence

  sequence s_skip;
    skip_now;
  endsequence

  AST_CLR_FILE: assert property (@(posedge clk_sys_i) disable iff (reset_i)
    exec_go && instr_i.op == OP_CLR_FILE |=>
      fwr_q.we && fwr_q.data == 8'h00 && null_q)
    else $error("clear file failed");

  AST_DEC_DEST: assert property (@(posedge clk_sys_i) disable iff (reset_i)
    exec_go && instr_i.op == OP_DEC_FILE && !instr_i.dest |=>
      acc_q == $past(file_rdata_i) - 8'h01 && !fwr_q.we)
    else $error("decrement to accumulator failed");

  AST_CLR_ACC: assert property (@(posedge clk_sys_i) disable iff (reset_i)
    exec_go && instr_i.op == OP_CLR_ACC |=> acc_q == 8'h00 && null_q)
    else $error("clear accumulator failed");

  AST_SKIP_FLAG: assert property (@(posedge clk_sys_i) disable iff (reset_i)
    exec_go && (instr_i.op == OP_DEC_SKIP || instr_i.op == OP_INC_SKIP)
      |=> $stable(null_q))
    else $error("skip changed flag");

  AST_SKIP_NOP: assert property (@(posedge clk_sys_i) disable iff (reset_i)
    s_skip |=> flush_o ##1 !flush_o)
    else $error("skip not two cycles");

  AST_INC_WR: assert property (@(posedge clk_sys_i) disable iff (reset_i)
    exec_go && instr_i.op == OP_INC_SKIP && instr_i.dest |=>
      fwr_q.we && fwr_q.data == $past(file_rdata_i) + 8'h01)
    else $error("increment write failed");

  AST_INC_NOSKIP: assert property (@(posedge clk_sys_i) disable iff (reset_i)
    exec_go && instr_i.op == OP_INC_SKIP && file_rdata_i != 8'hFF
      |=> !flush_o)
    else $error("nonzero increment skipped");

  AST_JUMP_PC: assert property (@(posedge clk_sys_i) disable iff (reset_i)
    s_jump |=> pc_q[10:0] == $past(instr_i.imm)
      && pc_q[14:11] == $past(pc_high_latch_i[6:3]) ##1 !flush_o)
    else $error("jump target wrong");

  AST_JUMP_FLUSH: assert property (@(posedge clk_sys_i) disable iff (reset_i)
    s_jump |=> flush_o && $stable(null_q))
    else $error("jump did not flush");

  AST_OR_LIT: assert property (@(posedge clk_sys_i) disable iff (reset_i)
    exec_go && instr_i.op == OP_OR_LIT |=>
      acc_q == ($past(acc_q) | $past(instr_i.imm[7:0]))
      && null_q == (acc_q == 8'h00))
    else $error("or literal failed");

  AST_DEC_NULL: assert property (@(posedge clk_sys_i) disable iff (reset_i)
    exec_go && instr_i.op == OP_DEC_FILE |=>
      null_q == ($past(file_rdata_i) == 8'h01))
    else $error("null flag wrong");

  AST_ONE_CYCLE: assert property (@(posedge clk_sys_i) disable iff (reset_i)
    exec_go && (instr_i.op == OP_CLR_FILE || instr_i.op == OP_DEC_FILE
      || instr_i.op == OP_OR_LIT) |=> !flush_o)
    else $error("single cycle op stalled");

  sequence s_nop_slot;
    flush_o ##1 !flush_o;
  endsequence

  AST_DEC_WR: assert property (@(posedge clk_sys_i) disable iff (reset_i)
    exec_go && instr_i.op == OP_DEC_FILE && instr_i.dest |=>
      fwr_q.we && fwr_q.data == $past(file_rdata_i) - 8'h01
      && fwr_q.addr == $past(instr_i.faddr))
    else $error("decrement to register failed");

  AST_DSKIP_ACC: assert property (@(posedge clk_sys_i) disable iff (reset_i)
    exec_go && instr_i.op == OP_DEC_SKIP && !instr_i.dest |=>
      acc_q == $past(file_rdata_i) - 8'h01 && !fwr_q.we)
    else $error("decrement skip to accumulator failed");

  AST_DSKIP_WR: assert property (@(posedge clk_sys_i) disable iff (reset_i)
    exec_go && instr_i.op == OP_DEC_SKIP && instr_i.dest |=>
      fwr_q.we && fwr_q.data == $past(file_rdata_i) - 8'h01
      && $stable(acc_q))
    else $error("decrement skip to register failed");

  AST_DSKIP_ZERO: assert property (@(posedge clk_sys_i) disable iff (reset_i)
    exec_go && instr_i.op == OP_DEC_SKIP && file_rdata_i == 8'h01
      |=> s_nop_slot)
    else $error("zero decrement did not skip");

  AST_DSKIP_GO: assert property (@(posedge clk_sys_i) disable iff (reset_i)
    exec_go && instr_i.op == OP_DEC_SKIP && file_rdata_i != 8'h01
      |=> !flush_o)
    else $error("nonzero decrement skipped");

  AST_INC_ACC: assert property (@(posedge clk_sys_i) disable iff (reset_i)
    exec_go && instr_i.op == OP_INC_SKIP && !instr_i.dest |=>
      acc_q == $past(file_rdata_i) + 8'h01 && !fwr_q.we)
    else $error("increment to accumulator failed");

  AST_ISKIP_ZERO: assert property (@(posedge clk_sys_i) disable iff (reset_i)
    exec_go && instr_i.op == OP_INC_SKIP && file_rdata_i == 8'hFF
      |=> s_nop_slot)
    else $error("zero increment did not skip");

  AST_JUMP_KEEP: assert property (@(posedge clk_sys_i) disable iff (reset_i)
    s_jump |=> $stable(acc_q) && !fwr_q.we)
    else $error("jump touched data");

  // the nop slot is refused: nothing may move while it stands
  AST_NOP_SLOT: assert property (@(posedge clk_sys_i) disable iff (reset_i)
    flush_o |=> $stable(acc_q) && $stable(null_q) && $stable(pc_q)
      && !fwr_q.we)
    else $error("nop slot executed");

  AST_CLR_ONE: assert property (@(posedge clk_sys_i) disable iff (reset_i)
    exec_go && instr_i.op == OP_CLR_ACC |=> !flush_o)
    else $error("clear accumulator stalled");

  AST_CLR_ADDR: assert property (@(posedge clk_sys_i) disable iff (reset_i)
    exec_go && instr_i.op == OP_CLR_FILE |=>
      fwr_q.addr == $past(instr_i.faddr) && $stable(acc_q))
    else $error("clear file address wrong");

  AST_OR_FLAG: assert property (@(posedge clk_sys_i) disable iff (reset_i)
    exec_go && instr_i.op == OP_OR_LIT
      && (acc_q | instr_i.imm[7:0]) != 8'h00 |=> !null_q)
    else $error("or literal null flag wrong");

  AST_CLR_ACC_WE: assert property (@(posedge clk_sys_i) disable iff (reset_i)
    exec_go && instr_i.op == OP_CLR_ACC |=> !fwr_q.we)
    else $error("clear accumulator wrote a register");

  AST_IDLE: assert property (@(posedge clk_sys_i) disable iff (reset_i)
    exec_go && instr_i.op == OP_NONE |=> !fwr_q.we && $stable(acc_q)
      && $stable(null_q) && !flush_o)
    else $error("no operation changed state");
endmodule

// >>> hdl/exec_pkg.sv
package exec_pkg;
  localparam int DATA_W = 8;
  localparam int FADDR_W = 7;
  localparam int PC_W = 15;
  localparam int JUMP_W = 11;
  localparam int LATCH_W = 7;
  localparam int LATCH_LO = 3;
  localparam logic [7:0] ZERO_BYTE = 8'h00;
  localparam logic [7:0] ONE_BYTE = 8'h01;
  localparam logic [7:0] ACC_RESET = 8'h00;
  localparam logic [14:0] PC_RESET = 15'h0000;

  typedef enum logic [2:0] {
    OP_NONE      = 3'b000,
    OP_CLR_FILE  = 3'b001,
    OP_DEC_FILE  = 3'b010,
    OP_CLR_ACC   = 3'b011,
    OP_DEC_SKIP  = 3'b100,
    OP_INC_SKIP  = 3'b101,
    OP_JUMP      = 3'b110,
    OP_OR_LIT    = 3'b111
  } op_e;

  typedef struct packed {
    op_e         op;
    logic        dest;
    logic [6:0]  faddr;
    logic [10:0] imm;
  } instr_s;

  typedef struct packed {
    logic       we;
    logic [6:0] addr;
    logic [7:0] data;
  } fwrite_s;
endpackage

// >>> tb/cpu_clear_dec_inc_branch_ops_tb_top.sv
module cpu_clear_dec_inc_branch_ops_tb_top
  import exec_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  // ==========================================================
  // stimulus and observed signals
  logic        clk_sys_i;
  logic        reset_i;
  logic        instr_valid_i;
  instr_s      instr_i;
  logic [7:0]  file_rdata_i;
  logic [6:0]  pc_high_latch_i;
  logic [14:0] pc_next_i;
  logic [6:0]  file_raddr_o;
  fwrite_s     file_wr_o;
  logic [7:0]  acc_o;
  logic        null_flag_o;
  logic [14:0] pc_o;
  logic        flush_o;
  logic        busy_o;
  int          err_total;
  int          n_compared;

  exec_unit exec_unit_i (
    .clk_sys_i       (clk_sys_i),
    .reset_i         (reset_i),
    .instr_valid_i   (instr_valid_i),
    .instr_i         (instr_i),
    .file_rdata_i    (file_rdata_i),
    .pc_high_latch_i (pc_high_latch_i),
    .pc_next_i       (pc_next_i),
    .file_raddr_o    (file_raddr_o),
    .file_wr_o       (file_wr_o),
    .acc_o           (acc_o),
    .null_flag_o     (null_flag_o),
    .pc_o            (pc_o),
    .flush_o         (flush_o),
    .busy_o          (busy_o)
  );

  // ==========================================================
  // shared tasks
  task automatic chk(input string nm, input logic [14:0] seen,
                     input logic [14:0] exp);
    n_compared++;
    if (seen !== exp) begin
      err_total++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  // inputs move 1 ns after the edge; returns 1 ns after the taking edge
  task automatic go(input op_e op, input logic d, input logic [6:0] fa,
                    input logic [10:0] imm, input logic [7:0] rd);
    instr_valid_i = 1'b1;
    instr_i = '{op: op, dest: d, faddr: fa, imm: imm};
    file_rdata_i = rd;
    @(posedge clk_sys_i);
    #1;
  endtask

  task automatic print_verdict();
    $display("compared %0d mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  // ==========================================================
  // scenarios
  task automatic t_acc();
    go(OP_OR_LIT, 1'b0, 7'h00, 11'h75A, 8'h00);
    chk("acc", 15'(acc_o), 15'h005A);
    chk("null", 15'(null_flag_o), 15'h0000);
    chk("pc", pc_o, pc_next_i);
    go(OP_CLR_ACC, 1'b0, 7'h00, 11'h000, 8'h00);
    chk("acc", 15'(acc_o), 15'h0000);
    chk("null", 15'(null_flag_o), 15'h0001);
    go(OP_OR_LIT, 1'b0, 7'h00, 11'h700, 8'h00);
    chk("null", 15'(null_flag_o), 15'h0001);
    $display("test accumulator done");
  endtask

  task automatic t_file();
    go(OP_CLR_FILE, 1'b0, 7'h7F, 11'h000, 8'hA5);
    chk("raddr", 15'(file_raddr_o), 15'h007F);
    chk("wr", {file_wr_o.addr, file_wr_o.data}, 15'h7F00);
    chk("we", 15'(file_wr_o.we), 15'h0001);
    chk("null", 15'(null_flag_o), 15'h0001);
    go(OP_DEC_FILE, 1'b1, 7'h11, 11'h000, 8'h00);
    chk("wr", {file_wr_o.addr, file_wr_o.data}, {7'h11, 8'hFF});
    chk("we", 15'(file_wr_o.we), 15'h0001);
    chk("null", 15'(null_flag_o), 15'h0000);
    go(OP_DEC_FILE, 1'b0, 7'h22, 11'h000, 8'h01);
    chk("we", 15'(file_wr_o.we), 15'h0000);
    chk("acc", 15'(acc_o), 15'h0000);
    chk("null", 15'(null_flag_o), 15'h0001);
    $display("test file done");
  endtask

  task automatic t_skip();
    logic [14:0] pc_held;
    go(OP_DEC_SKIP, 1'b1, 7'h05, 11'h000, 8'h01);
    chk("wr", {file_wr_o.addr, file_wr_o.data}, {7'h05, 8'h00});
    chk("we", 15'(file_wr_o.we), 15'h0001);
    chk("flush", 15'(flush_o), 15'h0001);
    chk("null", 15'(null_flag_o), 15'h0001);
    pc_held = pc_o;
    pc_next_i = 15'h2222;
    go(OP_OR_LIT, 1'b0, 7'h00, 11'h0FF, 8'h00);
    chk("acc", 15'(acc_o), 15'h0000);
    chk("pc", pc_o, pc_held);
    chk("flush", 15'(flush_o), 15'h0000);
    go(OP_INC_SKIP, 1'b0, 7'h06, 11'h000, 8'hFF);
    chk("acc", 15'(acc_o), 15'h0000);
    chk("flush", 15'(flush_o), 15'h0001);
    go(OP_NONE, 1'b0, 7'h00, 11'h000, 8'h00);
    go(OP_INC_SKIP, 1'b0, 7'h06, 11'h000, 8'h05);
    chk("acc", 15'(acc_o), 15'h0006);
    chk("flush", 15'(flush_o), 15'h0000);
    chk("null", 15'(null_flag_o), 15'h0001);
    go(OP_DEC_SKIP, 1'b0, 7'h06, 11'h000, 8'h03);
    chk("acc", 15'(acc_o), 15'h0002);
    chk("flush", 15'(flush_o), 15'h0000);
    go(OP_INC_SKIP, 1'b1, 7'h09, 11'h000, 8'h7F);
    chk("wr", {file_wr_o.addr, file_wr_o.data}, {7'h09, 8'h80});
    chk("we", 15'(file_wr_o.we), 15'h0001);
    chk("acc", 15'(acc_o), 15'h0002);
    chk("flush", 15'(flush_o), 15'h0000);
    $display("test skip done");
  endtask

  task automatic t_jump();
    pc_high_latch_i = 7'h55;
    go(OP_JUMP, 1'b0, 7'h00, 11'h7FF, 8'h00);
    chk("pc", pc_o, 15'h57FF);
    chk("flush", 15'(flush_o), 15'h0001);
    chk("busy", 15'(busy_o), 15'h0001);
    chk("null", 15'(null_flag_o), 15'h0001);
    go(OP_JUMP, 1'b0, 7'h00, 11'h001, 8'h00);
    chk("pc", pc_o, 15'h57FF);
    pc_high_latch_i = 7'h2A;
    go(OP_JUMP, 1'b0, 7'h00, 11'h123, 8'h00);
    chk("pc", pc_o, 15'h2923);
    go(OP_NONE, 1'b0, 7'h00, 11'h000, 8'h00);
    chk("flush", 15'(flush_o), 15'h0000);
    $display("test jump done");
  endtask

  // ==========================================================
  // clock, reset, sequence and watchdog
  initial begin
    clk_sys_i = 1'b0;
    forever #50 clk_sys_i = ~clk_sys_i;
  end

  initial begin
    err_total = 0;
    n_compared = 0;
    reset_i = 1'b1;
    instr_valid_i = 1'b0;
    instr_i = '0;
    file_rdata_i = 8'h00;
    pc_high_latch_i = 7'h00;
    pc_next_i = 15'h1234;
    repeat (3) @(posedge clk_sys_i);
    #1;
    chk("acc", 15'(acc_o), 15'(ACC_RESET));
    chk("pc", pc_o, PC_RESET);
    reset_i = 1'b0;
    t_acc();
    t_file();
    t_skip();
    t_jump();
    print_verdict();
  end

  // whole run is under 40 cycles; a hang past 1000 cycles is a failure
  initial begin
    #100000;
    err_total++;
    print_verdict();
  end
endmodule
